/* hdl/psq_program_sequencer.sv */
// program sequencer: phase generator, program counter, return stack
// assumes program memory answers combinationally within one pclk,
// decoder and interrupt logic run on pclk (no synchronisers needed)
//
// Contract
// - four phases per instruction cycle
// - counter advances entering fetch phase
// - fetch overlaps execution of previous word
// - jump and call take two cycles
// - counter increments after plain instructions
// - branches, interrupts, reset load target address
// - taken skip discards prefetch, dummy cycle
// - counter is low byte plus high bits
// - low byte readable and writable by software
// - low byte write jumps within page
// - low byte jump inserts one dummy cycle
// - stack and index hidden from software
// - call or interrupt acknowledge pushes counter
// - subroutine or interrupt exit pops counter
// - reset points index at stack top
// - full stack withholds interrupt acknowledge
// - held interrupt served after exit pops
// - call on full stack still executes
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps

module psq_program_sequencer (
  input  wire logic                      pclk,          // system clock
  input  wire logic                      presetn,       // async reset
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [psq_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // program memory
  output logic      [psq_pkg::PC_W-1:0]  pmem_addr,
  output logic                           fetch_strobe,
  input  wire logic [psq_pkg::INSTR_W-1:0] pmem_data,
  // instruction decoder
  output logic      [psq_pkg::INSTR_W-1:0] instr_word,
  output logic                           instr_valid,
  output psq_pkg::psq_phase_t            exec_phase,
  input  wire psq_pkg::psq_flow_t        flow_op,
  input  wire logic [psq_pkg::PC_W-1:0]  flow_target,
  // interrupt logic
  input  wire logic                      irq_req,
  input  wire logic [psq_pkg::PC_W-1:0]  irq_vector,
  output logic                           irq_ack
);
  import psq_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    psq_phase_t                     phase;     // current phase
    logic [PC_W-1:0]                pc;        // address being fetched
    logic [INSTR_W-1:0]             prefetch;  // word caught in fetch phase
    logic [INSTR_W-1:0]             ir;        // word under execution
    logic                           ir_valid;  // low in a dummy cycle
    logic                           fetch;     // fetch pulse
    logic                           ack;       // interrupt acknowledge pulse
    logic [IDX_W-1:0]               idx;       // return_stack_index
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;   // return entries
    logic                           pcl_pend;  // software low byte jump due
    logic [PC_LO_W-1:0]             pcl_data;  // new low byte
    logic                           run;       // ctrl run bit
    logic                           held;      // interrupt held by full stack
    logic [31:0]                    rdata;     // apb read data
    logic                           rdy;       // apb ready
    logic                           err;       // apb error
  } psq_state_t;

  psq_state_t st_reg;   // registered state
  psq_state_t st_next;  // next state

  // ==========================================================
  // helpers
  // register offset match, used by read and write decode
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic                t4_go;      // last phase, sequencer running
  psq_flow_t           op_live;    // decoder request, ignored in dummy
  logic                full;       // all six entries used
  logic                push_call;  // call executing now
  logic                pop_now;    // exit executing now
  logic                redirect;   // any flow request or a due low byte jump
  logic                take_irq;   // interrupt acknowledged now
  logic [PC_W-1:0]     pc_inc;     // sequential address
  logic [IDX_W-1:0]    idx_dec;    // index after a pop

  assign t4_go     = st_reg.run && (st_reg.phase == PH_T4);
  assign op_live   = st_reg.ir_valid ? flow_op : FLOW_NONE;
  assign full      = (st_reg.idx == IDX_FULL);
  assign push_call = t4_go && (op_live == FLOW_CALL);
  assign pop_now   = t4_go && ((op_live == FLOW_RET) || (op_live == FLOW_INTERRUPT_EXIT_INSTRUCTION));
  assign redirect  = (op_live != FLOW_NONE) || st_reg.pcl_pend;
  // interrupt waits behind any other flow change and a full stack
  assign take_irq  = t4_go && irq_req && !full && !redirect;
  assign pc_inc    = st_reg.pc + {{(PC_W-1){1'b0}}, 1'b1};
  assign idx_dec   = st_reg.idx - IDX_ONE;

  // ==========================================================
  // next state
  always_comb begin
    st_next       = st_reg;
    st_next.fetch = 1'b0;
    st_next.ack   = 1'b0;
    // held flag: live view of a request blocked by the full stack
    st_next.held  = irq_req && full;

    // ---------------- phase sequencing
    if (st_reg.run) begin
      case (st_reg.phase)
        PH_T1: begin
          // fetch of the next word overlaps execution of ir
          st_next.prefetch = pmem_data;
          st_next.phase    = PH_T2;
        end
        PH_T2: begin
          st_next.phase = PH_T3;
        end
        PH_T3: begin
          st_next.phase = PH_T4;
        end
        PH_T4: begin
          st_next.phase    = PH_T1;
          st_next.fetch    = 1'b1;
          st_next.ir       = st_reg.prefetch;
          st_next.ir_valid = 1'b1;
          st_next.pc       = pc_inc;
          if (op_live == FLOW_JUMP) begin
            // target known now, branch done in a dummy slot
            st_next.pc       = flow_target;
            st_next.ir_valid = 1'b0;
          end else if (op_live == FLOW_CALL) begin
            st_next.pc       = flow_target;
            st_next.ir_valid = 1'b0;
            if (full) begin
              // overflow: newest entry lost, return goes astray
              st_next.stack[STACK_DEPTH-1] = st_reg.pc;
            end else begin
              st_next.stack[st_reg.idx] = st_reg.pc;
              st_next.idx = st_reg.idx + IDX_ONE;
            end
          end else if (pop_now) begin
            st_next.ir_valid = 1'b0;
            if (st_reg.idx != IDX_TOP) begin
              st_next.pc  = st_reg.stack[idx_dec];
              st_next.idx = idx_dec;
            end else begin
              // underflow: entry zero reused
              st_next.pc = st_reg.stack[0];
            end
          end else if (op_live == FLOW_SKIP) begin
            // prefetched word dropped, sequential fetch continues
            st_next.ir_valid = 1'b0;
          end else if (st_reg.pcl_pend) begin
            // page stays, only low byte replaced
            st_next.pc       = {st_reg.pc[PC_W-1:PC_LO_W], st_reg.pcl_data};
            st_next.ir_valid = 1'b0;
            st_next.pcl_pend = 1'b0;
          end else if (take_irq) begin
            st_next.stack[st_reg.idx] = st_reg.pc;
            st_next.idx      = st_reg.idx + IDX_ONE;
            st_next.pc       = irq_vector;
            st_next.ir_valid = 1'b0;
            st_next.ack      = 1'b1;
          end
        end
        default: begin
          st_next.phase = PH_T1;
        end
      endcase
    end

    // ---------------- apb setup: decode and prepare answer
    if (psel && !penable) begin
      st_next.rdata = 32'h0000_0000;
      st_next.err   = 1'b0;
      if (hit(paddr, OFF_PCL)) begin
        // low byte of the word being executed next
        st_next.rdata[PC_LO_W-1:0] = st_reg.pc[PC_LO_W-1:0];
      end else if (hit(paddr, OFF_CTRL)) begin
        st_next.rdata[CTRL_RUN_BIT] = st_reg.run;
      end else if (hit(paddr, OFF_STATUS)) begin
        // stack index deliberately absent from this view
        st_next.rdata[STAT_DUMMY_BIT] = !st_reg.ir_valid;
        st_next.rdata[STAT_HELD_BIT]  = st_reg.held;
        st_next.rdata[STAT_PHASE_LSB +: 2] = st_reg.phase;
      end else begin
        st_next.err = 1'b1;  // unmapped address
      end
    end

    // ---------------- apb access: writes take effect here
    // placed after sequencing so a new write beats a consumed one
    if (psel && penable && pwrite && st_reg.rdy) begin
      if (hit(paddr, OFF_PCL)) begin
        st_next.pcl_pend = 1'b1;
        st_next.pcl_data = pwdata[PC_LO_W-1:0];
      end else if (hit(paddr, OFF_CTRL)) begin
        st_next.run = pwdata[CTRL_RUN_BIT];
      end
    end
  end

  // ==========================================================
  // state register
  // one register for all state keeps every output a flop;
  // the reset branch loads constants only, nothing derived
  // the first instruction cycle after reset is a dummy slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg          <= '0;
      st_reg.phase    <= PH_T1;
      st_reg.pc       <= RESET_VECTOR;
      st_reg.idx      <= IDX_TOP;
      st_reg.run      <= CTRL_RUN_RST;
      st_reg.rdy      <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs, straight from the state register
  // no output logic here, so decoder and memory see clean edges
  // read data stands until the next setup cycle
  assign prdata       = st_reg.rdata;
  assign pready       = st_reg.rdy;
  assign pslverr      = st_reg.err;
  assign pmem_addr    = st_reg.pc;
  assign fetch_strobe = st_reg.fetch;
  assign instr_word   = st_reg.ir;
  assign instr_valid  = st_reg.ir_valid;
  assign exec_phase   = st_reg.phase;
  assign irq_ack      = st_reg.ack;

  // ==========================================================
  // checks
  // last phase always hands over to fetch, then decode
  AST_PHASE_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    t4_go |=> (st_reg.phase == PH_T1) ##1 (st_reg.phase == PH_T2))
    else $error("phase did not wrap to fetch");

  // the fetch pulse may only mark the fetch phase
  AST_FETCH_T1: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_strobe |-> (exec_phase == PH_T1) && $changed(st_reg.ir)
                     || (exec_phase == PH_T1))
    else $error("fetch strobe outside fetch phase");

  // sequential flow steps the counter by exactly one
  AST_PC_INC: assert property (@(posedge pclk) disable iff (!presetn)
    t4_go && !redirect && !take_irq |=> pmem_addr == $past(pmem_addr) + 1'b1)
    else $error("counter did not step by one");

  // a jump or taken skip costs one whole dummy cycle
  AST_BRANCH_DUMMY: assert property (@(posedge pclk) disable iff (!presetn)
    t4_go && (op_live == FLOW_JUMP || op_live == FLOW_SKIP)
    |=> !instr_valid [*4])
    else $error("branch slot not a dummy cycle");

  // a call with room on the stack moves the index up one
  AST_PUSH: assert property (@(posedge pclk) disable iff (!presetn)
    push_call && !full |=> st_reg.idx == $past(st_reg.idx) + IDX_ONE)
    else $error("call did not push");

  // an exit restores the saved return address
  AST_POP: assert property (@(posedge pclk) disable iff (!presetn)
    pop_now && st_reg.idx != IDX_TOP
    |=> st_reg.idx == $past(idx_dec) && pmem_addr == $past(st_reg.stack[idx_dec]))
    else $error("exit did not restore counter");

  // full stack: no acknowledge, no push (an exit may still pop)
  AST_FULL_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    t4_go && irq_req && full && !pop_now |=> !irq_ack && st_reg.idx == IDX_FULL)
    else $error("interrupt taken on full stack");

  // a low byte write keeps the page bits
  AST_PCL_PAGE: assert property (@(posedge pclk) disable iff (!presetn)
    t4_go && op_live == FLOW_NONE && st_reg.pcl_pend
    |=> pmem_addr == {$past(pmem_addr[PC_W-1:PC_LO_W]), $past(st_reg.pcl_data)}
        && !instr_valid)
    else $error("low byte jump left page or skipped dummy");

  // interrupt entry: vector loaded, one acknowledge pulse
  AST_IRQ_ACK: assert property (@(posedge pclk) disable iff (!presetn)
    take_irq |=> irq_ack && pmem_addr == $past(irq_vector) ##1 !irq_ack)
    else $error("interrupt entry malformed");

  // taken skip: sequential address, dropped word replaced by dummy
  // catches a skip that wrongly reloads a target
  AST_SKIP_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    t4_go && op_live == FLOW_SKIP |=> pmem_addr == $past(pmem_addr) + 1'b1 && !instr_valid)
    else $error("skip did not step into a dummy cycle");

  // low byte jump: the whole next instruction cycle is a dummy
  // without it the stale prefetched word would execute
  AST_PCL_DUMMY: assert property (@(posedge pclk) disable iff (!presetn)
    t4_go && op_live == FLOW_NONE && st_reg.pcl_pend |=> !instr_valid [*4])
    else $error("low byte jump without dummy cycle");

  // first edge after reset release: index still at the top
  // no disable iff here, the release edge itself is the point
  AST_RESET_TOP: assert property (@(posedge pclk)
    !$past(presetn) && presetn |-> st_reg.idx == IDX_TOP)
    else $error("stack index not at top after reset");

  // index never runs past six entries, even on overflow calls
  // an overflowing call must overwrite, not grow the index
  AST_IDX_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.idx <= IDX_FULL)
    else $error("stack index beyond depth");

  // fetch overlaps execute: the executing word is the prefetch
  // a wrong pipe would show the word at the new address instead
  AST_IR_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    t4_go |=> instr_word == $past(st_reg.prefetch))
    else $error("executing word not the prefetched one");

  // every instruction cycle after the first one out of reset opens with a fetch pulse
  // decoder relies on it to mark the new address
  AST_FETCH_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    t4_go |=> fetch_strobe)
    else $error("no fetch pulse entering fetch phase");

  // a request blocked by a full stack shows in the held flag
  // software can see why an interrupt is late
  AST_HELD_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req && full |=> st_reg.held)
    else $error("held flag not raised on full stack");

  // call on a full stack still branches, index stays put
  // return behaviour after this is not guaranteed
  AST_CALL_FULL: assert property (@(posedge pclk) disable iff (!presetn)
    push_call && full |=> pmem_addr == $past(flow_target) && st_reg.idx == IDX_FULL)
    else $error("call on full stack mishandled");

endmodule // psq_program_sequencer

/* hdl/psq_pkg.sv */
// constants and types for the program sequencer and return stack
// assumes a single 50 MHz clock and an apb register port
package psq_pkg;

  // ==========================================================
  // program counter geometry
  localparam int PC_LO_W       = 8;   // low byte, software visible
  localparam int PC_HI_W_SMALL = 2;   // high bits, 1k word variant
  localparam int PC_HI_W_LARGE = 3;   // high bits, 2k word variant
  localparam int PC_HI_W       = PC_HI_W_LARGE;
  localparam int PC_W          = PC_LO_W + PC_HI_W;
  localparam int INSTR_W       = 15;  // program memory word
  localparam logic [PC_W-1:0] RESET_VECTOR = 11'h000;

  // ==========================================================
  // return stack
  localparam int STACK_DEPTH = 6;
  localparam int IDX_W       = 3;
  localparam logic [IDX_W-1:0] IDX_TOP  = 3'h0; // empty, after reset
  localparam logic [IDX_W-1:0] IDX_FULL = 3'h6;
  localparam logic [IDX_W-1:0] IDX_ONE  = 3'h1;

  // ==========================================================
  // apb register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_PCL    = 8'h00; // program_counter_low
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h04; // run control
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08; // sequencer state
  localparam int CTRL_RUN_BIT    = 0;
  localparam logic CTRL_RUN_RST  = 1'b1;
  localparam int STAT_DUMMY_BIT  = 0;  // current slot is a dummy cycle
  localparam int STAT_HELD_BIT   = 1;  // interrupt held off by full stack
  localparam int STAT_PHASE_LSB  = 4;  // two bits of phase

  // ==========================================================
  // phases of one instruction cycle
  typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} psq_phase_t;

  // flow request from the instruction decoder, sampled in the last phase
  typedef enum logic [2:0] {
    FLOW_NONE, FLOW_JUMP, FLOW_CALL, FLOW_RET, FLOW_INTERRUPT_EXIT_INSTRUCTION, FLOW_SKIP
  } psq_flow_t;

endpackage

/* bench/psq_partner_model.sv */
// partner: combinational program memory plus decoder stand-in
// assumes the sequencer samples flow_op only at the edge ending T4
`timescale 1ns/10ps
// ==========================================================
// memory and decoder model
module psq_partner_model (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [psq_pkg::PC_W-1:0] pmem_addr,
  output logic [psq_pkg::INSTR_W-1:0]  pmem_data,
  input  wire psq_pkg::psq_phase_t     exec_phase,
  input  wire logic                    instr_valid,
  output psq_pkg::psq_flow_t           flow_op,
  output logic [psq_pkg::PC_W-1:0]     flow_target,
  input  wire logic                    cmd_go,
  input  wire psq_pkg::psq_flow_t      cmd_op,
  input  wire logic [psq_pkg::PC_W-1:0] cmd_target,
  output logic                         busy
);
  import psq_pkg::*;
  logic            pend_reg; // request waiting for a live T4
  psq_flow_t       op_reg;   // decoder answer to present
  logic [PC_W-1:0] tgt_reg;  // branch target to present
  logic            take;     // request offered this slot
  // word carries its own address so the bench can predict it
  assign pmem_data = {4'hA, pmem_addr};
  // a dummy slot decodes nothing, so hold the request back
  assign take = pend_reg && instr_valid && (exec_phase == PH_T4);
  assign flow_op = take ? op_reg : FLOW_NONE;
  // off-slot target is scrambled, never left looking valid
  assign flow_target = take ? tgt_reg : ~tgt_reg;
  assign busy = pend_reg;
  // one pending request at a time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 1'b0;
      op_reg   <= FLOW_NONE;
      tgt_reg  <= 11'h000;
    end else if (cmd_go) begin
      pend_reg <= 1'b1;
      op_reg   <= cmd_op;
      tgt_reg  <= cmd_target;
    end else if (take) begin
      pend_reg <= 1'b0;
    end
  end
endmodule // psq_partner_model

/* bench/program_sequencer_stack_tb_top.sv */
// self-checking bench for the program sequencer and return stack
// assumes psq_partner_model answers for memory and decoder
`timescale 1ns/10ps
module program_sequencer_stack_tb_top;
  import psq_pkg::*;
  // ==========================================================
  // signals
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0]  paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [PC_W-1:0]    pmem_addr, flow_target, irq_vector, cmd_target, prev, r;
  logic [INSTR_W-1:0] pmem_data, instr_word;
  logic               fetch_strobe, instr_valid, irq_req, irq_ack, cmd_go, busy;
  psq_phase_t         exec_phase;
  psq_flow_t          flow_op, cmd_op;
  int                 n_fail, checks_done, acks;
  psq_program_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pmem_addr(pmem_addr),
    .fetch_strobe(fetch_strobe), .pmem_data(pmem_data), .instr_word(instr_word),
    .instr_valid(instr_valid), .exec_phase(exec_phase), .flow_op(flow_op),
    .flow_target(flow_target), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_ack(irq_ack));
  psq_partner_model far (.pclk(pclk), .presetn(presetn), .pmem_addr(pmem_addr),
    .pmem_data(pmem_data), .exec_phase(exec_phase), .instr_valid(instr_valid),
    .flow_op(flow_op), .flow_target(flow_target), .cmd_go(cmd_go),
    .cmd_op(cmd_op), .cmd_target(cmd_target), .busy(busy));
  // ==========================================================
  // shared tasks
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic step;
    @(posedge pclk);
    #1;
  endtask
  // waits past the edge that enters the next fetch phase
  task automatic to_t1;
    int n;
    n = 0;
    do begin
      step();
      n++;
    end while (fetch_strobe !== 1'b1 && n < 12);
    if (fetch_strobe !== 1'b1) begin
      n_fail++;
      $display("Error fetch wait expected 1 seen 0");
    end
  endtask
  // one apb transfer; waits on pready, never assumes its timing
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_fail++;
      $display("Error pready wait expected 1 seen 0");
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // hands one request to the decoder model, returns past its edge
  task automatic flow(input psq_flow_t op, input logic [PC_W-1:0] t);
    int n;
    @(posedge pclk);
    cmd_go <= 1'b1;
    cmd_op <= op;
    cmd_target <= t;
    @(posedge pclk);
    cmd_go <= 1'b0;
    #1;
    n = 0;
    do begin
      prev = pmem_addr;
      step();
      n++;
    end while (busy === 1'b1 && n < 20);
    if (busy !== 1'b0) begin
      n_fail++;
      $display("Error flow wait expected 0 seen 1");
    end
  endtask
  task automatic landed(input logic [PC_W-1:0] e);
    chk("branch address", e, pmem_addr);
    chk("dummy slot", 1'b0, instr_valid);
    to_t1();
    chk("target word", {4'hA, e}, instr_word);
    chk("valid after dummy", 1'b1, instr_valid);
  endtask
  // ==========================================================
  // scenarios
  task automatic s_plain;
    repeat (3) begin
      r = pmem_addr;
      to_t1();
      chk("increment", r + 11'h001, pmem_addr);
      chk("overlap word", {4'hA, r}, instr_word);
      for (int p = 1; p < 4; p++) begin
        step();
        chk("phase", p, exec_phase);
        chk("strobe outside fetch", 1'b0, fetch_strobe);
      end
    end
  endtask
  task automatic s_branch;
    flow(FLOW_JUMP, 11'h2F0);
    landed(11'h2F0);
    flow(FLOW_CALL, 11'h155);
    r = prev;
    landed(11'h155);
    flow(FLOW_RET, 11'h000);
    landed(r);
    flow(FLOW_SKIP, 11'h000);
    landed(prev + 11'h001);
  endtask
  task automatic s_regs;
    to_t1();
    r = {pmem_addr[10:8], 8'h3C};
    apb(1'b1, OFF_PCL, 32'h0000003C);
    to_t1();
    landed(r);
    apb(1'b0, OFF_PCL, 32'h00000000);
    chk("low byte read", {24'h000000, r[7:0] + 8'h01}, rd);
    apb(1'b0, 8'h0C, 32'h00000000);
    chk("unmapped error", 1'b1, err);
    chk("unmapped data", 32'h00000000, rd);
  endtask
  task automatic s_full;
    for (int i = 0; i < 6; i++) begin
      flow(FLOW_CALL, 11'h100 + 11'(i * 8));
    end
    @(posedge pclk);
    irq_vector <= 11'h7F0;
    irq_req <= 1'b1;
    acks = 0;
    repeat (16) begin
      step();
      acks += int'(irq_ack === 1'b1);
    end
    chk("acks while full", 0, acks);
    apb(1'b0, OFF_STATUS, 32'h00000000);
    chk("held flag", 1'b1, rd[STAT_HELD_BIT]);
    flow(FLOW_CALL, 11'h200);
    chk("call on full", 11'h200, pmem_addr);
    flow(FLOW_RET, 11'h000);
    for (int n = 0; n < 16 && irq_ack !== 1'b1; n++) begin
      prev = pmem_addr;
      step();
    end
    chk("held irq served", 1'b1, irq_ack);
    r = prev;
    irq_req <= 1'b0;
    landed(11'h7F0);
    flow(FLOW_INTERRUPT_EXIT_INSTRUCTION, 11'h000);
    landed(r);
  endtask
  // ==========================================================
  // clock, watchdog, main sequence
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {presetn, psel, penable, pwrite, irq_req, cmd_go} = 6'h00;
    {paddr, pwdata, irq_vector, cmd_target} = '0;
    cmd_op = FLOW_NONE;
    n_fail = 0;
    checks_done = 0;
    repeat (19) @(posedge pclk);
    #1;
    chk("reset address", RESET_VECTOR, pmem_addr);
    chk("reset phase", PH_T1, exec_phase);
    chk("reset valid", 1'b0, instr_valid);
    @(posedge pclk);
    presetn <= 1'b1;
    s_plain();
    s_branch();
    s_regs();
    s_full();
    tally_and_finish();
  end
endmodule // program_sequencer_stack_tb_top
